//--- hdl/acd_clock_control.sv
`timescale 1ns/1ps
`include "acd_defs.svh"
module acd_clock_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic sync_in,
  input wire logic power_down_pin,
  input wire logic duty_cycle_stabilizer_en,
  input wire logic clk_freq_changed,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic div_clk_en,
  output logic serial_out_en_n,
  output logic reference_on,
  output logic core_on,
  output logic dcs_settling,
  output acd_pkg::acd_state_t power_state
);
  import acd_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Bit 0 carries the divider sync pin and bit 1 the power-down pin.
  wire logic [1:0] pin_raw = {power_down_pin, sync_in};
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic sync_prev_q;
  // Both pins come from the board, so each passes two flops before any logic reads it.
  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < 2; pin_idx = pin_idx + 1)
    begin : g_pin_sync
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          pin_meta_q[pin_idx] <= 1'b0;
          pin_sync_q[pin_idx] <= 1'b0;
        end
        else
        begin
          pin_meta_q[pin_idx] <= pin_raw[pin_idx];
          pin_sync_q[pin_idx] <= pin_meta_q[pin_idx];
        end
      end
    end
  endgenerate
  // The edge detector resets low, the idle level of the sync pin, so reset release shows no false edge.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sync_prev_q <= 1'b0;
    else
      sync_prev_q <= pin_sync_q[0];
  end
  wire logic sync_rise = pin_sync_q[0] & ~sync_prev_q;
  wire logic power_down_pin_level = pin_sync_q[1];

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Write strobes and the read mux both decode the map.
  // One function keeps the two from drifting apart.
  function automatic logic addr_is(input logic [9:0] addr, input logic [9:0] offset);
    addr_is = (addr == offset);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] div_sync_q;
  logic [2:0] div_ratio_q;
  logic [1:0] power_mode_q;
  logic armed_q;
  // Write strobes, one per writable register; writes to status or unmapped addresses strobe nothing.
  wire logic wr_sync = reg_wr & addr_is(reg_addr, `ACD_REG_DIV_SYNC);
  wire logic wr_ratio = reg_wr & addr_is(reg_addr, `ACD_REG_DIV_RATIO);
  wire logic wr_power = reg_wr & addr_is(reg_addr, `ACD_REG_POWER_MODE);
  wire logic sync_enabled = div_sync_q[`ACD_SYNC_EN_BIT];
  wire logic sync_oneshot = div_sync_q[`ACD_SYNC_ONESHOT_BIT];
  // In one-shot mode only the first pulse after a write is accepted.
  wire logic sync_accept = sync_rise & sync_enabled & (~sync_oneshot | armed_q);
  // Sync control and its one-shot arm; a write re-arms and wins over a pulse accepted in the same cycle.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_sync_q <= `ACD_DIV_SYNC_RESET;
      armed_q <= 1'b0;
    end
    else if (wr_sync)
    begin
      div_sync_q <= reg_wdata;
      armed_q <= 1'b1;
    end
    else if (sync_accept)
      armed_q <= 1'b0;
  end

  // A lowered ratio is compared at once, so a count already past it runs on until the counter rolls over.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div_ratio_q <= `ACD_DIV_RATIO_RESET;
    else if (wr_ratio)
      div_ratio_q <= reg_wdata[2:0];
  end

  // Mode 3 is reserved and falls through to normal operation in the state decode.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      power_mode_q <= `ACD_POWER_MODE_RESET;
    else if (wr_power)
      power_mode_q <= reg_wdata[1:0];
  end

  // ----------------------------------------
  // Clock divider
  // ----------------------------------------
  logic [2:0] div_cnt_q;
  logic div_en_q;
  // Ratio field holds divide-by minus one, so 0 is divide by 1.
  wire logic div_wrap = (div_cnt_q == div_ratio_q);
  // An accepted sync forces the counter to zero so all parts align.
  // Power-down holds it there as well, so wake-up starts from a known phase.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt_q <= 3'h0;
      div_en_q <= 1'b0;
    end
    else if (sync_accept | (power_state == ACD_ST_DOWN))
    begin
      div_cnt_q <= 3'h0;
      div_en_q <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_wrap ? 3'h0 : div_cnt_q + 3'h1;
      div_en_q <= div_wrap;
    end
  end
  assign div_clk_en = div_en_q;

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  acd_state_t state_q;
  acd_state_t state_d;
  // Full power-down wins over standby; exit needs both sources idle.
  // Pin and mode field are both levels, so neither request can be lost.
  always_comb
  begin
    case (1'b1)
      power_down_pin_level, (power_mode_q == ACD_PM_POWER_DOWN): state_d = ACD_ST_DOWN;
      (power_mode_q == ACD_PM_STANDBY): state_d = ACD_ST_STANDBY;
      default: state_d = ACD_ST_RUN;
    endcase
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_q <= ACD_ST_RUN;
    else
      state_q <= state_d;
  end
  assign power_state = state_q;
  // Drivers float whenever conversion is not running; enable is active low.
  // Standby keeps the reference up for a quicker wake-up while core and drivers rest.
  assign serial_out_en_n = (state_q != ACD_ST_RUN);
  assign reference_on = (state_q != ACD_ST_DOWN);
  assign core_on = (state_q == ACD_ST_RUN);

  // ----------------------------------------
  // Stabilizer settling flag
  // ----------------------------------------
  logic [6:0] dcs_cnt_q;
  // Flags the least wait so the system knows when conversions are trusted.
  // Only the lower bound is flagged; keeping within the upper bound is up to the system.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      dcs_cnt_q <= 7'h0;
    else if (clk_freq_changed & duty_cycle_stabilizer_en)
      dcs_cnt_q <= 7'(`ACD_DCS_WAIT_CYCLES);
    else if (dcs_cnt_q != 7'h0)
      dcs_cnt_q <= dcs_cnt_q - 7'h1;
  end
  assign dcs_settling = (dcs_cnt_q != 7'h0);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] rdata_q;
  // Status packs the state, the settling flag and the one-shot arm.
  wire logic [7:0] rd_mux = addr_is(reg_addr, `ACD_REG_DIV_SYNC) ? div_sync_q :
    addr_is(reg_addr, `ACD_REG_DIV_RATIO) ? {5'h0, div_ratio_q} :
    addr_is(reg_addr, `ACD_REG_POWER_MODE) ? {6'h0, power_mode_q} :
    addr_is(reg_addr, `ACD_REG_STATUS) ? {4'h0, armed_q, dcs_settling, state_q} : 8'h00;
  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (reg_rd)
      rdata_q <= rd_mux;
  end
  assign reg_rdata = rdata_q;
endmodule

//--- hdl/acd_defs.svh
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define ACD_REG_DIV_SYNC 10'h109
`define ACD_REG_DIV_RATIO 10'h10B
`define ACD_REG_POWER_MODE 10'h008
`define ACD_REG_STATUS 10'h10C
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ACD_SYNC_EN_BIT 0
`define ACD_SYNC_ONESHOT_BIT 1
`define ACD_DIV_SYNC_RESET 8'h00
`define ACD_DIV_RATIO_RESET 3'h0
`define ACD_POWER_MODE_RESET 2'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define ACD_CLK_MHZ 50
`define ACD_DCS_WAIT_MIN_NS 1500
`define ACD_DCS_WAIT_CYCLES ((`ACD_DCS_WAIT_MIN_NS * `ACD_CLK_MHZ + 999) / 1000)
`endif

//--- hdl/acd_pkg.sv
package acd_pkg;
  // Power modes written through the control port.
  typedef enum logic [1:0] {ACD_PM_NORMAL, ACD_PM_POWER_DOWN, ACD_PM_STANDBY, ACD_PM_RSVD} acd_power_mode_t;
  typedef enum logic [1:0] {ACD_ST_RUN, ACD_ST_STANDBY, ACD_ST_DOWN} acd_state_t;
endpackage

//--- tb/acd_board.sv
`timescale 1ns/1ps
// ----
// Board pins
// ----
module acd_board (
  input wire logic clk,
  input wire logic sync_go,
  input wire logic pd_level,
  output logic sync_in,
  output logic power_down_pin
);
  // Pins change just after an edge, as a board register would drive them.
  always @(posedge clk)
  begin
    sync_in <= sync_go;
    power_down_pin <= pd_level;
  end
endmodule

//--- tb/acd_clock_control_assertions.sv
`timescale 1ns/1ps
`include "acd_defs.svh"
// ----
// Port checker
// ----
module acd_chk
  import acd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sync_in,
  input wire logic power_down_pin,
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic div_clk_en,
  input wire logic serial_out_en_n,
  input wire logic reference_on,
  input wire logic core_on,
  input wire acd_pkg::acd_state_t power_state
);
  logic [1:0] mode_q;
  logic [3:0] gap_q;
  wire pm_wr = reg_wr && reg_addr == `ACD_REG_POWER_MODE;
  // Mirror the mode field; the gap count restarts on anything that may stretch a divider period.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= 2'h0;
      gap_q <= 4'h0;
    end
    else
    begin
      if (pm_wr) mode_q <= reg_wdata[1:0];
      gap_q <= (div_clk_en || sync_in || reg_wr || power_state != ACD_ST_RUN) ? 4'h0 : gap_q + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence pin_low3;
    !power_down_pin [*3];
  endsequence
  chk_standby_pins: assert property (power_state == ACD_ST_STANDBY |-> serial_out_en_n && reference_on && !core_on)
    else $error("standby pins");
  chk_down_pins: assert property (power_state == ACD_ST_DOWN |-> serial_out_en_n && !reference_on && !core_on)
    else $error("down pins");
  chk_run_pins: assert property (power_state == ACD_ST_RUN |-> !serial_out_en_n && core_on)
    else $error("run pins");
  chk_pin_forces_down: assert property (power_down_pin [*4] |-> power_state == ACD_ST_DOWN)
    else $error("pin down");
  chk_reg_down: assert property (pm_wr && reg_wdata[1:0] == 2'h1 |-> ##[1:2] power_state == ACD_ST_DOWN)
    else $error("reg down");
  chk_reg_standby: assert property (pin_low3 ##0 pm_wr && reg_wdata[1:0] == 2'h2 |-> ##[1:3] power_state == ACD_ST_STANDBY)
    else $error("standby");
  chk_exit_run: assert property ((!power_down_pin && mode_q != 2'h1 && mode_q != 2'h2) [*5] |-> power_state == ACD_ST_RUN)
    else $error("exit");
  chk_div_gap_bound: assert property (gap_q < 4'hc)
    else $error("divider gap");
endmodule
bind acd_clock_control acd_chk u_chk (.*);

//--- tb/test_adc_clock_divider_powerdown.sv
`timescale 1ns/1ps
`include "acd_defs.svh"
// ----
// Bench
// ----
module test_adc_clock_divider_powerdown import acd_pkg::*;;
  logic clk = 0, reset = 1, sync_go = 0, pd_level = 0, duty_cycle_stabilizer_en = 0, clk_freq_changed = 0;
  logic reg_wr = 0, reg_rd = 0, sync_in, power_down_pin, div_clk_en, serial_out_en_n, reference_on, core_on, dcs_settling;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
  acd_state_t power_state;
  int fails = 0, total_checks = 0, n, m;
  acd_clock_control i_dut (.*);
  acd_board i_board (.*);
  initial forever #10 clk = ~clk;
  task wrap_up;
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rreg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait for the next divider pulse; a hang ends the run.
  task till_pulse(output int k);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (div_clk_en !== 1'b1 && k < 40);
    if (div_clk_en !== 1'b1)
    begin
      fails++;
      wrap_up;
    end
  endtask
  task sync_shot(output int k);
    @(posedge clk);
    sync_go <= 1;
    @(posedge clk);
    sync_go <= 0;
    repeat (4) @(negedge clk);
    till_pulse(k);
  endtask
  task power(input logic p, input logic [1:0] md, input acd_state_t e);
    wreg(`ACD_REG_POWER_MODE, {6'h00, md});
    pd_level <= p;
    repeat (6) @(negedge clk);
    chk("power_state", {6'h00, e}, {6'h00, power_state});
    chk("power_pins", {5'h00, e != ACD_ST_RUN, e != ACD_ST_DOWN, e == ACD_ST_RUN},
      {5'h00, serial_out_en_n, reference_on, core_on});
  endtask
  // Main sequence: registers, every ratio, sync, power modes, settling.
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 0;
    rreg(`ACD_REG_DIV_SYNC, v);
    chk("div_sync", `ACD_DIV_SYNC_RESET, v);
    rreg(10'h3ff, v);
    chk("unmapped", 8'h00, v);
    for (int r = 0; r < 8; r++)
    begin
      wreg(`ACD_REG_DIV_RATIO, 8'(r));
      repeat (3) till_pulse(n);
      chk("period", 8'(r + 1), 8'(n));
    end
    rreg(`ACD_REG_DIV_RATIO, v);
    chk("div_ratio", 8'h07, v);
    wreg(`ACD_REG_DIV_SYNC, 8'h01);
    sync_shot(n);
    for (int d = 1; d < 3; d++)
    begin
      repeat (d) @(posedge clk);
      sync_shot(m);
      chk("sync_offset", 8'(n), 8'(m));
    end
    wreg(`ACD_REG_DIV_SYNC, 8'h03);
    rreg(`ACD_REG_STATUS, v);
    chk("armed", 8'h01, {7'h00, v[3]});
    sync_shot(n);
    chk("sync_first", 8'h08, 8'(n));
    rreg(`ACD_REG_STATUS, v);
    chk("armed", 8'h00, {7'h00, v[3]});
    // A spent one-shot, or sync disabled, leaves the phase alone: next pulse 8 - 5 edges on.
    till_pulse(n);
    sync_shot(m);
    chk("sync_spent", 8'h03, 8'(m));
    wreg(`ACD_REG_DIV_SYNC, 8'h00);
    till_pulse(n);
    sync_shot(m);
    chk("sync_disabled", 8'h03, 8'(m));
    power(1, 2'h0, ACD_ST_DOWN);
    power(1, 2'h2, ACD_ST_DOWN);
    power(0, 2'h0, ACD_ST_RUN);
    power(0, 2'h1, ACD_ST_DOWN);
    power(0, 2'h2, ACD_ST_STANDBY);
    power(0, 2'h3, ACD_ST_RUN);
    @(posedge clk);
    clk_freq_changed <= 1;
    @(posedge clk);
    clk_freq_changed <= 0;
    @(negedge clk);
    chk("settling_off", 8'h00, {7'h00, dcs_settling});
    @(posedge clk);
    duty_cycle_stabilizer_en <= 1;
    clk_freq_changed <= 1;
    @(posedge clk);
    clk_freq_changed <= 0;
    @(negedge clk);
    chk("settling", 8'h01, {7'h00, dcs_settling});
    repeat (`ACD_DCS_WAIT_CYCLES - 1) @(posedge clk);
    @(negedge clk);
    chk("settling_last", 8'h01, {7'h00, dcs_settling});
    @(negedge clk);
    chk("settling", 8'h00, {7'h00, dcs_settling});
    wrap_up;
  end
endmodule
